// *** verilog/tlim_mapper.sv ***
// torque limit selection with ramped switching, and sequence input pin function mapping
// ----------------------------------------------------------------
// Operation
// - source 1 clamps both directions to the first limit.
// - source 2 uses first limit forward, second limit reverse.
// - source 3 uses first limit when switch input off, second when on.
// - source 6: first/second when off, external forward/reverse limits when on.
// - with feed-forward, limit only in speed control with sources 1 to 3.
// - ramping applies only with source 3.
// - first-to-second uses slope one, second-to-first uses slope two.
// - ramp direction follows comparison of the two limit magnitudes.
// - rewriting first or second limit applies at once, skipping the ramp.
// - limits range 0 to cap (300 default, lower caps possible), reset 300.
// - each of ten input pins has its own selection register.
// - pin polarity selectable; some functions refused on some pins.
// - make contact: active while shorted to return line.
// - break contact: active while open from return line.
// - reset loads default pin allocations.
// - one code byte per control mode; active mode picks the byte.
// - code top bit selects break contact.
// - same function on two pins in the position or speed byte raises duplicate alarm.
// ----------------------------------------------------------------
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module tlim_mapper
   import tlim_pkg::*;
#(
   parameter logic [LIM_W-1:0] TORQUE_CAP = LIM_MAX_DEFAULT
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sequence input pins, high while shorted to the return line
   input wire logic [PIN_COUNT-1:0] input_pin_shorted,
   // torque path
   input wire logic signed [15:0] torque_cmd,
   output logic signed [15:0] torque_out,
   output logic [LIM_W-1:0] fwd_limit,
   output logic [LIM_W-1:0] rev_limit,
   // mapped drive functions and alarms
   output logic [FUNC_N-1:0] func_active,
   output logic dup_alarm
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [LIM_W-1:0] sat(input logic [31:0] v);
      return (v > 32'(TORQUE_CAP)) ? TORQUE_CAP : v[LIM_W-1:0];
   endfunction

   function automatic logic [7:0] code_of(input logic [31:0] sel, input logic [1:0] mode);
      return sel[mode*8 +: 8];
   endfunction

   function automatic logic allowed(input logic [7:0] code, input int pin);
      logic ok;
      ok = code[6:0] != FN_NONE && code[6:0] < 7'(FUNC_N);
      if (code[NC_BIT] && (code[6:0] == FN_ALARM_RESET || code[6:0] == FN_ERR_CLEAR)) begin
         ok = 1'b0;
      end
      if (code[6:0] == FN_ERR_CLEAR && pin != ERR_CLEAR_PIN) begin
         ok = 1'b0;
      end
      if (code[6:0] == FN_PULSE_INHIBIT && pin != PULSE_INHIBIT_PIN) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   function automatic logic [LIM_W-1:0] ramp_step(input logic [LIM_W-1:0] cur, input logic [LIM_W-1:0] tgt,
                                                input logic [LIM_W-1:0] slope);
      if (slope == '0) begin
         return tgt;
      end else if (cur < tgt) begin
         return (tgt - cur <= slope) ? tgt : LIM_W'(cur + slope);
      end else begin
         return (cur - tgt <= slope) ? tgt : LIM_W'(cur - slope);
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [2:0] source_sel;
   logic [LIM_W-1:0] first_lim, second_lim, slope_1to2, slope_2to1, fwd_ext, rev_ext;
   logic [1:0] ctrl_mode;
   logic ff_select;
   logic [31:0] pin_sel [PIN_COUNT];
   logic limit_rewritten;
   logic dup_pos, dup_spd, alloc_err;

   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [5:0] wr_index;
   logic wr_is_pin, wr_mapped;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_index = aw_addr[7:2];
   assign wr_is_pin = aw_addr >= OFS_PIN_BASE && wr_index < 6'(OFS_PIN_BASE[7:2] + PIN_COUNT);
   assign wr_mapped = wr_is_pin || aw_addr <= OFS_CONTROL;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_mapped && aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign aw_held = !s_axi_awready;
   assign w_held = !s_axi_wready;

   // present value of the addressed register, merged with the written byte lanes
   logic [31:0] wr_old, wr_word;
   always_comb begin
      unique case (aw_addr)
         OFS_SOURCE_SEL: wr_old = {29'h0, source_sel};
         OFS_FIRST_LIM: wr_old = {23'h0, first_lim};
         OFS_SECOND_LIM: wr_old = {23'h0, second_lim};
         OFS_SLOPE_1TO2: wr_old = {23'h0, slope_1to2};
         OFS_SLOPE_2TO1: wr_old = {23'h0, slope_2to1};
         OFS_FWD_EXT: wr_old = {23'h0, fwd_ext};
         OFS_REV_EXT: wr_old = {23'h0, rev_ext};
         OFS_CONTROL: wr_old = {29'h0, ff_select, ctrl_mode};
         default: wr_old = wr_is_pin ? pin_sel[4'(wr_index - OFS_PIN_BASE[7:2])] : 32'h0000_0000;
      endcase
      wr_word = merge(wr_old, w_data, w_strb);
   end

   // software-visible settings; a write is also the steer for the limit logic
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         source_sel <= SEL_RESET;
         first_lim <= LIM_RESET;
         second_lim <= LIM_RESET;
         slope_1to2 <= SLOPE_RESET;
         slope_2to1 <= SLOPE_RESET;
         fwd_ext <= LIM_RESET;
         rev_ext <= LIM_RESET;
         ctrl_mode <= MODE_POSITION;
         ff_select <= 1'b0;
         for (int p = 0; p < PIN_COUNT; p++) begin
            pin_sel[p] <= PIN_RESET[p];
         end
      end else if (do_write && aw_addr[1:0] == 2'b00) begin
         unique case (aw_addr)
            OFS_SOURCE_SEL: source_sel <= wr_word[2:0];
            OFS_FIRST_LIM: first_lim <= sat(wr_word);
            OFS_SECOND_LIM: second_lim <= sat(wr_word);
            OFS_SLOPE_1TO2: slope_1to2 <= wr_word[LIM_W-1:0];
            OFS_SLOPE_2TO1: slope_2to1 <= wr_word[LIM_W-1:0];
            OFS_FWD_EXT: fwd_ext <= sat(wr_word);
            OFS_REV_EXT: rev_ext <= sat(wr_word);
            OFS_CONTROL: begin
               ctrl_mode <= wr_word[CTRL_MODE_LSB +: 2];
               ff_select <= wr_word[CTRL_FF_BIT];
            end
            default: begin
               if (wr_is_pin) begin
                  pin_sel[4'(wr_index - OFS_PIN_BASE[7:2])] <= wr_word;
               end
            end
         endcase
      end
   end

   // read channel: one cycle from address to data
   logic [5:0] rd_index;
   logic [31:0] next_rdata;
   logic next_rerr;
   assign rd_index = s_axi_araddr[7:2];

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;
      unique case (s_axi_araddr)
         OFS_SOURCE_SEL: next_rdata = {29'h0, source_sel};
         OFS_FIRST_LIM: next_rdata = {23'h0, first_lim};
         OFS_SECOND_LIM: next_rdata = {23'h0, second_lim};
         OFS_SLOPE_1TO2: next_rdata = {23'h0, slope_1to2};
         OFS_SLOPE_2TO1: next_rdata = {23'h0, slope_2to1};
         OFS_FWD_EXT: next_rdata = {23'h0, fwd_ext};
         OFS_REV_EXT: next_rdata = {23'h0, rev_ext};
         OFS_CONTROL: next_rdata = {29'h0, ff_select, ctrl_mode};
         OFS_LIMIT_STAT: next_rdata = {7'h0, rev_limit, 7'h0, fwd_limit};
         OFS_FUNC_STAT: next_rdata = {dup_pos, dup_spd, alloc_err, 7'h0, func_active};
         default: begin
            if (s_axi_araddr >= OFS_PIN_BASE && s_axi_araddr[1:0] == 2'b00
                && rd_index < 6'(OFS_PIN_BASE[7:2] + PIN_COUNT)) begin
               next_rdata = pin_sel[4'(rd_index - OFS_PIN_BASE[7:2])];
            end else begin
               next_rerr = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // input pin mapping
   // ----------------------------------------------------------------
   // pins are asynchronous to the clock, so two stages before any use
   logic [PIN_COUNT-1:0] pin_meta, pin_sync;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= input_pin_shorted;
         pin_sync <= pin_meta;
      end
   end

   logic [FUNC_N-1:0] next_func;
   logic next_dup_pos, next_dup_spd, next_alloc_err;
   always_comb begin
      logic [7:0] c;
      c = 8'h00;
      next_func = '0;
      next_alloc_err = 1'b0;
      for (int p = 0; p < PIN_COUNT; p++) begin
         c = code_of(pin_sel[p], ctrl_mode);
         if (allowed(c, p)) begin
            next_func[c[4:0]] = next_func[c[4:0]] | (pin_sync[p] ^ c[NC_BIT]);
         end else if (c[6:0] != FN_NONE) begin
            next_alloc_err = 1'b1;
         end
      end
   end

   // duplicates are checked in the position and speed bytes only, both at all times
   always_comb begin
      next_dup_pos = 1'b0;
      next_dup_spd = 1'b0;
      for (int a = 0; a < PIN_COUNT; a++) begin
         for (int b = a + 1; b < PIN_COUNT; b++) begin
            if (pin_sel[a][6:0] != FN_NONE && pin_sel[a][6:0] == pin_sel[b][6:0]) begin
               next_dup_pos = 1'b1;
            end
            if (pin_sel[a][14:8] != FN_NONE && pin_sel[a][14:8] == pin_sel[b][14:8]) begin
               next_dup_spd = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         func_active <= '0;
         dup_pos <= 1'b0;
         dup_spd <= 1'b0;
         alloc_err <= 1'b0;
         dup_alarm <= 1'b0;
      end else begin
         func_active <= next_func;
         dup_pos <= next_dup_pos;
         dup_spd <= next_dup_spd;
         alloc_err <= next_alloc_err;
         dup_alarm <= next_dup_pos | next_dup_spd;
      end
   end

   // ----------------------------------------------------------------
   // torque limit selection and ramp
   // ----------------------------------------------------------------
   logic [6:0] tick_count;
   logic tick;
   assign tick = tick_count == 7'(CTRL_TICKS - 1);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tick_count <= 7'h00;
      end else begin
         tick_count <= tick ? 7'h00 : 7'(tick_count + 7'h01);
      end
   end

   logic limit_switch_input;
   logic [LIM_W-1:0] ramp_target, ramp_slope, ramp_cur;
   assign limit_switch_input = func_active[FN_LIMIT_SWITCH[4:0]];
   assign ramp_target = limit_switch_input ? second_lim : first_lim;
   assign ramp_slope = limit_switch_input ? slope_1to2 : slope_2to1;

   // a rewrite between ticks is remembered; a new write wins over the tick that clears it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         limit_rewritten <= 1'b0;
      end else if (do_write && (aw_addr == OFS_FIRST_LIM || aw_addr == OFS_SECOND_LIM)) begin
         limit_rewritten <= 1'b1;
      end else if (tick) begin
         limit_rewritten <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ramp_cur <= LIM_RESET;
      end else if (tick) begin
         if (source_sel == SEL_SWITCHED && !limit_rewritten) begin
            ramp_cur <= ramp_step(ramp_cur, ramp_target, ramp_slope);
         end else begin
            ramp_cur <= ramp_target;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fwd_limit <= LIM_RESET;
         rev_limit <= LIM_RESET;
      end else if (tick) begin
         unique case (source_sel)
            SEL_BOTH_FIRST: begin
               fwd_limit <= first_lim;
               rev_limit <= first_lim;
            end
            SEL_SPLIT: begin
               fwd_limit <= first_lim;
               rev_limit <= second_lim;
            end
            SEL_SWITCHED: begin
               fwd_limit <= (limit_rewritten) ? ramp_target : ramp_step(ramp_cur, ramp_target, ramp_slope);
               rev_limit <= (limit_rewritten) ? ramp_target : ramp_step(ramp_cur, ramp_target, ramp_slope);
            end
            SEL_EXTERNAL: begin
               fwd_limit <= limit_switch_input ? fwd_ext : first_lim;
               rev_limit <= limit_switch_input ? rev_ext : second_lim;
            end
            // reserved codes keep the last limits rather than open the clamp
            default: begin
               fwd_limit <= fwd_limit;
               rev_limit <= rev_limit;
            end
         endcase
      end
   end

   // clamp uses the limits already in force, one control cycle behind a switch
   logic enforce;
   logic signed [15:0] fwd_s, rev_s;
   assign enforce = !ff_select || (ctrl_mode == MODE_SPEED && source_sel >= SEL_BOTH_FIRST
                    && source_sel <= SEL_SWITCHED);
   assign fwd_s = $signed({7'h00, fwd_limit});
   assign rev_s = -$signed({7'h00, rev_limit});

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         torque_out <= 16'sh0000;
      end else if (tick) begin
         if (enforce && torque_cmd > fwd_s) begin
            torque_out <= fwd_s;
         end else if (enforce && torque_cmd < rev_s) begin
            torque_out <= rev_s;
         end else begin
            torque_out <= torque_cmd;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_source_one: assert property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_BOTH_FIRST |=> fwd_limit == $past(first_lim) && rev_limit == $past(first_lim))
      else $error("source one limits differ from first limit");
   a_source_two: assert property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_SPLIT |=> fwd_limit == $past(first_lim) && rev_limit == $past(second_lim))
      else $error("source two split limits wrong");
   a_switched_same: assert property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_SWITCHED |=> fwd_limit == rev_limit && fwd_limit == ramp_cur)
      else $error("switched source limits not common");
   a_external_on: assert property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_EXTERNAL && limit_switch_input |=> fwd_limit == $past(fwd_ext)
      && rev_limit == $past(rev_ext))
      else $error("external limits not applied");
   a_ff_bypass: assert property (@(posedge clock) disable iff (!rst_n)
      tick && ff_select && ctrl_mode != MODE_SPEED |=> torque_out == $past(torque_cmd))
      else $error("feed-forward outside speed mode still clamped");
   a_clamp_fwd: assert property (@(posedge clock) disable iff (!rst_n)
      tick && enforce && torque_cmd > fwd_s |=> torque_out == $past(fwd_s))
      else $error("positive command not clamped");
   a_ramp_land: assert property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_SWITCHED && ramp_cur < ramp_target && ramp_target - ramp_cur <= ramp_slope
      |=> ramp_cur == $past(ramp_target))
      else $error("ramp missed its target");
   a_rewrite_direct: assert property (@(posedge clock) disable iff (!rst_n)
      tick && limit_rewritten |=> ramp_cur == $past(ramp_target))
      else $error("rewritten limit was ramped");
   a_limit_cap: assert property (@(posedge clock) disable iff (!rst_n)
      first_lim <= TORQUE_CAP && second_lim <= TORQUE_CAP)
      else $error("limit above cap");
   a_dup_alarm: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(next_dup_pos) ##1 1'b1 |-> dup_alarm && dup_pos)
      else $error("duplicate allocation not flagged");

   c_ramp_step: cover property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_SWITCHED && ramp_cur != ramp_target && ramp_slope != '0);
   c_external: cover property (@(posedge clock) disable iff (!rst_n)
      tick && source_sel == SEL_EXTERNAL && limit_switch_input);
   c_clamp_rev: cover property (@(posedge clock) disable iff (!rst_n) tick && enforce && torque_cmd < rev_s);
   c_duplicate: cover property (@(posedge clock) disable iff (!rst_n) dup_alarm);
endmodule

// *** verilog/tlim_pkg.sv ***
// package: register map, reset values, function codes and timing for the torque limit and input mapper
package tlim_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_SOURCE_SEL = 8'h00;
   localparam logic [7:0] OFS_FIRST_LIM = 8'h04;
   localparam logic [7:0] OFS_SECOND_LIM = 8'h08;
   localparam logic [7:0] OFS_SLOPE_1TO2 = 8'h0C;
   localparam logic [7:0] OFS_SLOPE_2TO1 = 8'h10;
   localparam logic [7:0] OFS_FWD_EXT = 8'h14;
   localparam logic [7:0] OFS_REV_EXT = 8'h18;
   localparam logic [7:0] OFS_CONTROL = 8'h1C;
   localparam logic [7:0] OFS_LIMIT_STAT = 8'h20;
   localparam logic [7:0] OFS_FUNC_STAT = 8'h24;
   localparam logic [7:0] OFS_PIN_BASE = 8'h40;
   localparam int PIN_COUNT = 10;
   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int LIM_W = 9;
   localparam logic [LIM_W-1:0] LIM_RESET = 9'h12C;
   localparam logic [LIM_W-1:0] LIM_MAX_DEFAULT = 9'h12C;
   localparam logic [LIM_W-1:0] SLOPE_RESET = 9'h000;
   localparam logic [2:0] SEL_RESET = 3'h1;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FF_BIT = 2;
   localparam int STAT_REV_LSB = 16;
   localparam int FUNC_N = 22;
   localparam int ALARM_DUP_POS_BIT = 31;
   localparam int ALARM_DUP_SPD_BIT = 30;
   localparam int ALARM_ALLOC_BIT = 29;
   localparam int NC_BIT = 7;
   localparam logic [31:0] PIN_RESET [PIN_COUNT] = '{
      32'h0082_8282, 32'h0081_8181, 32'h0091_910A, 32'h0006_0606, 32'h0000_100C,
      32'h0003_0303, 32'h0000_0F07, 32'h0004_0404, 32'h0005_0505, 32'h0000_0E88};
   // ----------------------------------------------------------------
   // modes and function codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_POSITION = 2'h0;
   localparam logic [1:0] MODE_SPEED = 2'h1;
   localparam logic [2:0] SEL_BOTH_FIRST = 3'h1;
   localparam logic [2:0] SEL_SPLIT = 3'h2;
   localparam logic [2:0] SEL_SWITCHED = 3'h3;
   localparam logic [2:0] SEL_EXTERNAL = 3'h6;
   localparam logic [6:0] FN_NONE = 7'h00;
   localparam logic [6:0] FN_ALARM_RESET = 7'h04;
   localparam logic [6:0] FN_ERR_CLEAR = 7'h07;
   localparam logic [6:0] FN_PULSE_INHIBIT = 7'h08;
   localparam logic [6:0] FN_LIMIT_SWITCH = 7'h09;
   localparam int ERR_CLEAR_PIN = 6;
   localparam int PULSE_INHIBIT_PIN = 9;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CTRL_CYCLE_NS = 1000;
   localparam int CTRL_TICKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
endpackage

// *** testbench/tlim_pin_ctrl.sv ***
// pin controller model that opens or shorts the sequence input pins
module tlim_pin_ctrl
   import tlim_pkg::*;
(
   // clock
   input wire logic clock,
   // requested and present pin state
   input wire logic [PIN_COUNT-1:0] want_short,
   output logic [PIN_COUNT-1:0] shorted
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins move only after an edge, as a relay contact would
   always @(posedge clock) shorted <= want_short;
endmodule

// *** testbench/tb.sv ***
// testbench: register reset values, limit selection, clamping and pin mapping
module tb;
   import tlim_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, dup, h1, h2, hv;
   logic [1:0] bresp, rresp, rs;
   logic [PIN_COUNT-1:0] want = 0, shorted;
   logic signed [15:0] cmd = 0, tout;
   logic [LIM_W-1:0] fwd, rev;
   logic [FUNC_N-1:0] func;
   logic [7:0] row_a [12];
   logic [31:0] row_e [12];
   int errors = 0, comparisons = 0;
   always #5 clock = ~clock;
   tlim_pin_ctrl tlim_pin_ctrl_inst (.clock(clock), .want_short(want), .shorted(shorted));
   tlim_mapper tlim_mapper_inst (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .input_pin_shorted(shorted),
      .torque_cmd(cmd), .torque_out(tout), .fwd_limit(fwd), .rev_limit(rev), .func_active(func), .dup_alarm(dup));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ready and answer are sampled at the negedge before the edge that takes them
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      hv = 0;
      @(posedge clock);
      if (wr) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      else {araddr, arvalid, rready} <= {a, 2'b11};
      for (n = 0; n < 50 && hv !== 1; n++) begin
         @(negedge clock);
         h1 = wr ? awready : arready;
         h2 = wready;
         hv = wr ? bvalid : rvalid;
         {rd, rs} = wr ? {32'h0, bresp} : {rdata, rresp};
         @(posedge clock);
         if (h1 === 1 && wr) awvalid <= 0;
         if (h1 === 1 && !wr) arvalid <= 0;
         if (h2 === 1 && wr) wvalid <= 0;
      end
      {bready, rready} <= 2'b00;
      if (hv !== 1) begin
         errors++;
         finish_test();
      end
   endtask
   // waits for the first ramp step, then checks it and the step after
   task automatic ramp_seen(input logic [LIM_W-1:0] from, input logic [31:0] e1, input logic [31:0] e2);
      for (int n = 0; n < 300 && fwd === from; n++) @(negedge clock);
      if (fwd === from) begin
         errors++;
         finish_test();
      end
      check(fwd, e1);
      repeat (100) @(negedge clock);
      check({fwd, rev}, {e2[8:0], e2[8:0]});
   endtask
   task automatic ticks();
      repeat (250) @(posedge clock);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1;
      check(fwd, LIM_RESET);
      check(tout, 0);
      for (int i = 0; i < 12; i++) begin
         row_a[i] = i < 10 ? OFS_PIN_BASE + 8'(4 * i) : (i == 10 ? OFS_SOURCE_SEL : OFS_FIRST_LIM);
         row_e[i] = i < 10 ? PIN_RESET[i] : (i == 10 ? 32'(SEL_RESET) : 32'(LIM_RESET));
      end
      for (int i = 0; i < 12; i++) begin
         bus(0, row_a[i], 0);
         check(rd, row_e[i]);
      end
      $display("reset values done");
      bus(1, OFS_SECOND_LIM, 32'h0000_0064);
      check(rs, RESP_OKAY);
      bus(1, OFS_SOURCE_SEL, 32'h0000_0002);
      cmd <= -16'sd200;
      ticks();
      check({fwd, rev}, {9'h12C, 9'h064});
      check(tout, -32'sd100);
      cmd <= 16'sd400;
      ticks();
      check(tout, 32'h0000_012C);
      $display("split limits done");
      bus(1, OFS_PIN_BASE + 8'h0C, 32'h0000_0909);
      bus(1, OFS_SOURCE_SEL, 32'h0000_0003);
      want <= 10'h008;
      ticks();
      check(func[FN_LIMIT_SWITCH], 1);
      check({fwd, rev}, {9'h064, 9'h064});
      check(tout, 32'h0000_0064);
      $display("switched limits done");
      bus(1, OFS_FWD_EXT, 32'h0000_0032);
      bus(1, OFS_REV_EXT, 32'h0000_003C);
      bus(1, OFS_SOURCE_SEL, 32'h0000_0006);
      ticks();
      check({fwd, rev}, {9'h032, 9'h03C});
      bus(1, OFS_PIN_BASE + 8'h0C, 32'h0000_0089);
      ticks();
      check(func[FN_LIMIT_SWITCH], 0);
      check({fwd, rev}, {9'h12C, 9'h064});
      $display("external limits and break contact done");
      bus(1, OFS_PIN_BASE + 8'h10, 32'h0000_0089);
      ticks();
      check(dup, 1);
      bus(0, 8'hFC, 0);
      check(rs, RESP_SLVERR);
      check(rd, 0);
      $display("duplicate and unmapped done");
      {rst_n, want} <= {1'b0, 10'h000};
      repeat (3) @(posedge clock);
      rst_n <= 1;
      repeat (4) @(posedge clock);
      check({dup, fwd, func}, {1'b0, 9'h12C, 22'h00_0106});
      $display("mid-run reset done");
      bus(1, OFS_SECOND_LIM, 32'h0000_0064);
      bus(1, OFS_SLOPE_1TO2, 32'h0000_0064);
      bus(1, OFS_SLOPE_2TO1, 32'h0000_0078);
      bus(1, OFS_PIN_BASE + 8'h0C, 32'h0000_0909);
      bus(1, OFS_SOURCE_SEL, 32'h0000_0003);
      ticks();
      want <= 10'h008;
      ramp_seen(9'h12C, 32'h0C8, 32'h064);
      @(posedge clock);
      want <= 10'h000;
      ramp_seen(9'h064, 32'h0DC, 32'h12C);
      $display("ramped switching done");
      bus(1, OFS_CONTROL, 32'h0000_0005);
      ticks();
      check(func[17], 1);
      check(tout, 32'h0000_012C);
      bus(1, OFS_CONTROL, 32'h0000_0004);
      ticks();
      check(tout, 32'h0000_0190);
      $display("feed-forward and speed mode done");
      finish_test();
   end
endmodule
